// ===== common/cad_pkg.sv
// Opcode decoder constants, enumerations and lengths
`default_nettype none
package cad_pkg;
    localparam int CAD_DATA_W = 8;
    localparam int CAD_ADDR_W = 16;
    localparam logic [7:0] CAD_MUL_OPCODE = 8'h42;
    localparam logic [7:0] CAD_BSR_OPCODE = 8'had;
    localparam logic [2:0] CAD_LEN_ONE = 3'h1;
    localparam logic [2:0] CAD_LEN_TWO = 3'h2;
    localparam logic [2:0] CAD_LEN_THREE = 3'h3;
    localparam logic [15:0] CAD_PC_STEP_IMM = 16'h0001;
    localparam logic [7:0] CAD_ZERO_PAGE = 8'h00;
    localparam logic [15:0] CAD_RESET_PC = 16'h0000;

    // Ten addressing modes
    typedef enum logic [3:0] {
        implied_mode, operand_in_instruction_mode, short_absolute_mode, long_absolute_mode,
        indexed_no_offset_mode, indexed_byte_offset_mode, indexed_word_offset_mode,
        branch_offset_mode, bit_modify_mode, bit_test_branch_mode
    } cad_mode_t;

    // Operation groups by high nibble
    typedef enum logic [2:0] {
        grp_bit_test, grp_bit_modify, grp_branch, grp_rmw, grp_control, grp_regmem
    } cad_group_t;
endpackage : cad_pkg
`default_nettype wire

// ===== rtl/cad_decode.sv
// Combinational classification of one opcode byte
`default_nettype none
module cad_decode
    import cad_pkg::*;
(
    input wire logic [7:0] opcode,
    output cad_group_t group,
    output cad_mode_t mode,
    output logic [2:0] length,
    output logic unassigned,
    output logic [3:0] op_sel
);
    logic [3:0] hi;
    logic [3:0] lo;
    assign hi = opcode[7:4];
    assign lo = opcode[3:0];
    assign op_sel = lo;

    always_comb begin
        group = grp_control;
        mode = implied_mode;
        unassigned = 1'b0;
        case (hi)
            4'h0: begin group = grp_bit_test; mode = bit_test_branch_mode; end
            4'h1: begin group = grp_bit_modify; mode = bit_modify_mode; end
            4'h2: begin group = grp_branch; mode = branch_offset_mode; end
            4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
                group = grp_rmw;
                case (hi)
                    4'h3: mode = short_absolute_mode;
                    4'h6: mode = indexed_byte_offset_mode;
                    4'h7: mode = indexed_no_offset_mode;
                    default: mode = implied_mode;
                endcase
                if (opcode == CAD_MUL_OPCODE) begin
                    group = grp_control;
                end else if (lo == 4'h1 || lo == 4'h2 || lo == 4'h5 || lo == 4'hb || lo == 4'he) begin
                    unassigned = 1'b1;
                end
            end
            4'h8, 4'h9: begin
                group = grp_control;
                mode = implied_mode;
                if (hi == 4'h8) begin
                    unassigned = !(lo == 4'h0 || lo == 4'h1 || lo == 4'h3 || lo == 4'he || lo == 4'hf);
                end else begin
                    unassigned = !(lo == 4'h7 || (lo >= 4'h8 && lo <= 4'hd) || lo == 4'hf);
                end
            end
            default: begin
                group = grp_regmem;
                case (hi)
                    4'ha: mode = operand_in_instruction_mode;
                    4'hb: mode = short_absolute_mode;
                    4'hc: mode = long_absolute_mode;
                    4'hd: mode = indexed_word_offset_mode;
                    4'he: mode = indexed_byte_offset_mode;
                    default: mode = indexed_no_offset_mode;
                endcase
                if (opcode == CAD_BSR_OPCODE) begin
                    mode = branch_offset_mode;
                end
                if (opcode == 8'ha7 || opcode == 8'hac || opcode == 8'haf) begin
                    unassigned = 1'b1;
                end
            end
        endcase
    end

    // Length follows the mode alone
    always_comb begin
        case (mode)
            implied_mode, indexed_no_offset_mode: length = CAD_LEN_ONE;
            long_absolute_mode, indexed_word_offset_mode, bit_test_branch_mode: length = CAD_LEN_THREE;
            default: length = CAD_LEN_TWO;
        endcase
    end
endmodule : cad_decode
`default_nettype wire

// ===== rtl/cad_opcode_decoder.sv
// Opcode decoder with effective address and next program counter
`default_nettype none
module cad_opcode_decoder
    import cad_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic fetch_valid,
    input wire logic [7:0] opcode,
    input wire logic [7:0] operand1,
    input wire logic [7:0] operand2,
    input wire logic [15:0] pc,
    input wire logic [7:0] index_reg,
    input wire logic [7:0] tested_byte,
    input wire logic [7:0] ccr,
    input wire logic irq_line_high,
    output cad_group_t group,
    output cad_mode_t mode,
    output logic [2:0] length,
    output logic unassigned,
    output logic [3:0] op_sel,
    output logic [2:0] bit_number,
    output logic bit_sense,
    output logic [15:0] effective_location,
    output logic [15:0] next_pc_out,
    output logic branch_taken,
    output logic carry_from_bit,
    output logic dec_valid
);
    // Condition code bit positions: H I N Z C
    localparam int CC_H = 4;
    localparam int CC_I = 3;
    localparam int CC_N = 2;
    localparam int CC_Z = 1;
    localparam int CC_C = 0;

    cad_group_t c_group;
    cad_mode_t c_mode;
    logic [2:0] c_len;
    logic c_unas;
    logic [3:0] c_sel;

    cad_decode u_decode (
        .opcode(opcode),
        .group(c_group),
        .mode(c_mode),
        .length(c_len),
        .unassigned(c_unas),
        .op_sel(c_sel)
    );

    logic cond;
    logic bit_val;
    logic [15:0] ea;
    logic [15:0] npc;
    logic [15:0] pc_next_instr;
    logic [15:0] rel_ofs;
    logic [8:0] x_sum;
    logic [15:0] x_wsum;

    // Branch condition select; bit 0 of low nibble inverts the base test
    always_comb begin
        cond = 1'b0;
        case (opcode[3:1])
            3'h0: cond = 1'b1;
            3'h1: cond = !(ccr[CC_C] | ccr[CC_Z]);
            3'h2: cond = !ccr[CC_C];
            3'h3: cond = !ccr[CC_Z];
            3'h4: cond = !ccr[CC_H];
            3'h5: cond = !ccr[CC_N];
            3'h6: cond = !ccr[CC_I];
            3'h7: cond = !irq_line_high;
            default: cond = 1'b0;
        endcase
        if (opcode[0]) begin
            cond = !cond;
        end
        bit_val = tested_byte[opcode[3:1]];
    end

    // Address and counter arithmetic per mode
    always_comb begin
        pc_next_instr = pc + {13'h0000, c_len};
        rel_ofs = {{8{operand2[7]}}, operand2};
        x_sum = {1'b0, index_reg} + {1'b0, operand1};
        x_wsum = {operand1, operand2} + {8'h00, index_reg};
        ea = pc;
        npc = pc_next_instr;
        case (c_mode)
            operand_in_instruction_mode: ea = pc + CAD_PC_STEP_IMM;
            short_absolute_mode, bit_modify_mode: ea = {CAD_ZERO_PAGE, operand1};
            long_absolute_mode: ea = {operand1, operand2};
            indexed_no_offset_mode: ea = {CAD_ZERO_PAGE, index_reg};
            indexed_byte_offset_mode: ea = {7'h00, x_sum};
            indexed_word_offset_mode: ea = x_wsum;
            branch_offset_mode: begin
                ea = pc_next_instr + {{8{operand1[7]}}, operand1};
                if (opcode == CAD_BSR_OPCODE || cond) begin
                    npc = ea;
                end
            end
            bit_test_branch_mode: begin
                ea = {CAD_ZERO_PAGE, operand1};
                if (bit_val ^ opcode[0]) begin
                    npc = pc_next_instr + rel_ofs;
                end
            end
            default: ea = pc;
        endcase
    end

    logic next_dec_valid;
    logic next_taken;
    cad_group_t next_group;
    cad_mode_t next_mode;
    logic [2:0] next_length;
    logic next_unassigned;
    logic [3:0] next_op_sel;
    logic [2:0] next_bit_number;
    logic next_bit_sense;
    logic [15:0] next_effective_location;
    logic [15:0] next_npc_out;
    logic next_branch_taken;
    logic next_carry_from_bit;

    // Next register values; decode is held when no fetch is offered, so a stalled
    // datapath keeps the last address and counter without a separate enable
    always_comb begin
        next_dec_valid = fetch_valid;
        next_taken = (npc != pc_next_instr);
        next_group = group;
        next_mode = mode;
        next_length = length;
        next_unassigned = unassigned;
        next_op_sel = op_sel;
        next_bit_number = bit_number;
        next_bit_sense = bit_sense;
        next_effective_location = effective_location;
        next_npc_out = next_pc_out;
        next_branch_taken = branch_taken;
        next_carry_from_bit = carry_from_bit;
        if (fetch_valid) begin
            next_group = c_group;
            next_mode = c_mode;
            next_length = c_len;
            next_unassigned = c_unas;
            next_op_sel = c_sel;
            next_bit_number = opcode[3:1];
            next_bit_sense = opcode[0];
            next_effective_location = ea;
            next_npc_out = npc;
            next_branch_taken = next_taken;
            next_carry_from_bit = bit_val;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            group <= grp_control;
            mode <= implied_mode;
            length <= CAD_LEN_ONE;
            unassigned <= 1'b0;
            op_sel <= 4'h0;
            bit_number <= 3'h0;
            bit_sense <= 1'b0;
            effective_location <= CAD_RESET_PC;
            next_pc_out <= CAD_RESET_PC;
            branch_taken <= 1'b0;
            carry_from_bit <= 1'b0;
            dec_valid <= 1'b0;
        end else begin
            dec_valid <= next_dec_valid;
            group <= next_group;
            mode <= next_mode;
            length <= next_length;
            unassigned <= next_unassigned;
            op_sel <= next_op_sel;
            bit_number <= next_bit_number;
            bit_sense <= next_bit_sense;
            effective_location <= next_effective_location;
            next_pc_out <= next_npc_out;
            branch_taken <= next_branch_taken;
            carry_from_bit <= next_carry_from_bit;
        end
    end

    // Assertions look one cycle after a taken request (the valid-drop and hold checks after an idle cycle); opcode-dependent parts use $past
    // so that they see the request itself and not the fetch that follows it
    // immediate address
    a_imm_address: assert property (@(posedge core_clk) disable iff (!nrst)
        fetch_valid && opcode[7:4] == 4'ha && opcode != CAD_BSR_OPCODE |=> effective_location == $past(pc) + 16'h0001
        && next_pc_out == $past(pc) + 16'h0002) else $error("immediate address wrong");
    a_direct_zero: assert property (@(posedge core_clk) disable iff (!nrst)
        fetch_valid && opcode[7:4] == 4'hb |=> effective_location == {8'h00, $past(operand1)}) else $error("direct wrong");
    a_ext_order: assert property (@(posedge core_clk) disable iff (!nrst)
        fetch_valid && opcode[7:4] == 4'hc |=> effective_location == {$past(operand1), $past(operand2)}
        && length == 3'h3) else $error("extended wrong");
    a_ix_plain: assert property (@(posedge core_clk) disable iff (!nrst)
        fetch_valid && opcode[7:4] == 4'hf |=> effective_location == {8'h00, $past(index_reg)} && length == 3'h1)
        else $error("indexed wrong");
    a_ix1_carry: assert property (@(posedge core_clk) disable iff (!nrst)
        fetch_valid && opcode[7:4] == 4'he |=> effective_location == 16'($past(index_reg)) + 16'($past(operand1)))
        else $error("byte offset wrong");
    a_ix2_carry: assert property (@(posedge core_clk) disable iff (!nrst)
        fetch_valid && opcode[7:4] == 4'hd |=> effective_location == {$past(operand1), $past(operand2)}
        + 16'($past(index_reg)) && next_pc_out == $past(pc) + 16'h0003) else $error("word offset wrong");
    a_mul_valid: assert property (@(posedge core_clk) disable iff (!nrst)
        fetch_valid && opcode == 8'h42 |=> !unassigned && mode == implied_mode) else $error("multiply wrong");
    a_rmw_holes: assert property (@(posedge core_clk) disable iff (!nrst)
        fetch_valid && opcode[7:4] inside {[4'h3:4'h7]} && opcode[3:0] inside {4'h1, 4'h5, 4'hb, 4'he}
        |=> unassigned) else $error("read-modify-write hole not flagged");
    a_bra_never: assert property (@(posedge core_clk) disable iff (!nrst)
        fetch_valid && opcode == 8'h21 |=> next_pc_out == $past(pc) + 16'h0002 && !branch_taken)
        else $error("never branch taken");
    a_bra_always: assert property (@(posedge core_clk) disable iff (!nrst)
        fetch_valid && opcode == 8'h20
        |=> next_pc_out == $past(pc) + 16'h0002 + {{8{$past(operand1[7])}}, $past(operand1)})
        else $error("always branch wrong");
    a_beq_zero: assert property (@(posedge core_clk) disable iff (!nrst)
        fetch_valid && opcode == 8'h27 && operand1 != 8'h00 |=> branch_taken == $past(ccr[1]))
        else $error("equal branch wrong");
    a_bit_carry: assert property (@(posedge core_clk) disable iff (!nrst)
        fetch_valid && opcode[7:4] == 4'h0 |=> carry_from_bit == $past(tested_byte[opcode[3:1]]))
        else $error("bit carry wrong");
    a_bit_fields: assert property (@(posedge core_clk) disable iff (!nrst)
        fetch_valid && opcode[7:5] == 3'h0 |=> bit_number == $past(opcode[3:1])
        && bit_sense == $past(opcode[0])) else $error("bit fields wrong");
    a_rmw_group: assert property (@(posedge core_clk) disable iff (!nrst)
        fetch_valid && opcode[7:4] inside {[4'h3:4'h7]} && opcode != 8'h42
        |=> group == grp_rmw) else $error("read-modify-write group wrong");
    a_ctrl_implied: assert property (@(posedge core_clk) disable iff (!nrst)
        fetch_valid && opcode[7:5] == 3'h4
        |=> group == grp_control && mode == implied_mode && length == 3'h1) else $error("control op wrong");
    a_bsr_rel: assert property (@(posedge core_clk) disable iff (!nrst)
        fetch_valid && opcode == 8'had |=> mode == branch_offset_mode
        && next_pc_out == $past(pc) + 16'h0002 + {{8{$past(operand1[7])}}, $past(operand1)})
        else $error("branch to subroutine wrong");
    a_inh_length: assert property (@(posedge core_clk) disable iff (!nrst)
        fetch_valid && opcode[7:5] == 3'h2
        |=> length == 3'h1 && mode == implied_mode) else $error("implied length wrong");
    a_valid_follow: assert property (@(posedge core_clk) disable iff (!nrst)
        fetch_valid |=> dec_valid) else $error("valid lost");
    a_valid_drop: assert property (@(posedge core_clk) disable iff (!nrst)
        !fetch_valid |=> !dec_valid) else $error("valid stood too long");
    a_hold_idle: assert property (@(posedge core_clk) disable iff (!nrst)
        !fetch_valid |=> $stable(effective_location) && $stable(next_pc_out) && $stable(mode))
        else $error("outputs moved while idle");

    // Main scenarios reached
    c_branch_taken: cover property (@(posedge core_clk) disable iff (!nrst) dec_valid && branch_taken);
    c_unassigned: cover property (@(posedge core_clk) disable iff (!nrst) dec_valid && unassigned);
    c_word_index: cover property (@(posedge core_clk) disable iff (!nrst) dec_valid && mode == indexed_word_offset_mode);
    c_bit_branch: cover property (@(posedge core_clk) disable iff (!nrst) dec_valid && mode == bit_test_branch_mode);
    c_multiply: cover property (@(posedge core_clk) disable iff (!nrst) dec_valid && op_sel == 4'h2 && group == grp_control);
endmodule : cad_opcode_decoder
`default_nettype wire

// ===== sim/cad_fetch_model.sv
// Fetch stage model: program memory presenting an opcode and its two following bytes
`default_nettype none
module cad_fetch_model
(
    input wire logic [15:0] pc,
    output logic [7:0] opcode,
    output logic [7:0] operand1,
    output logic [7:0] operand2
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:65535];

    // Bytes at the opcode address and the next two; the address wraps at 64K like the real counter
    assign opcode = mem[pc];
    assign operand1 = mem[pc + 16'h0001];
    assign operand2 = mem[pc + 16'h0002];

    // Loads one three-byte slot; unwritten locations stay unknown so stray fetches show up
    task automatic put(input logic [15:0] a, input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
        mem[a] = b0;
        mem[a + 16'h0001] = b1;
        mem[a + 16'h0002] = b2;
    endtask
endmodule // cad_fetch_model
`default_nettype wire

// ===== sim/cad_opcode_decoder_tb_top.sv
// Self-checking bench for the opcode decoder
`default_nettype none
module cad_opcode_decoder_tb_top
    import cad_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] PCB = 16'h1234;
    localparam cad_mode_t mode_tab [16] = '{bit_test_branch_mode, bit_modify_mode, branch_offset_mode,
        short_absolute_mode, implied_mode, implied_mode, indexed_byte_offset_mode, indexed_no_offset_mode,
        implied_mode, implied_mode, operand_in_instruction_mode, short_absolute_mode, long_absolute_mode,
        indexed_word_offset_mode, indexed_byte_offset_mode, indexed_no_offset_mode};
    localparam logic [2:0] len_tab [16] = '{3'h3, 3'h2, 3'h2, 3'h2, 3'h1, 3'h1, 3'h2, 3'h1,
        3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h2, 3'h1};
    localparam cad_group_t grp_tab [16] = '{grp_bit_test, grp_bit_modify, grp_branch, grp_rmw, grp_rmw,
        grp_rmw, grp_rmw, grp_rmw, grp_control, grp_control, grp_regmem, grp_regmem, grp_regmem,
        grp_regmem, grp_regmem, grp_regmem};
    logic core_clk = 1'b0, nrst = 1'b0, fetch_valid = 1'b0, irq_line_high = 1'b0;
    logic [15:0] pc = 16'h0000;
    logic [7:0] index_reg = 8'h00, tested_byte = 8'h00, ccr = 8'h00;
    logic [7:0] opcode, operand1, operand2;
    cad_group_t group;
    cad_mode_t mode;
    logic [2:0] length, bit_number;
    logic [3:0] op_sel;
    logic unassigned, bit_sense, branch_taken, carry_from_bit, dec_valid;
    logic [15:0] effective_location, next_pc_out;
    int err_total = 0;
    int checks_done = 0;

    cad_fetch_model u_fetch (.pc(pc), .opcode(opcode), .operand1(operand1), .operand2(operand2));
    cad_opcode_decoder u_dut (.core_clk(core_clk), .nrst(nrst), .fetch_valid(fetch_valid), .opcode(opcode),
        .operand1(operand1), .operand2(operand2), .pc(pc), .index_reg(index_reg), .tested_byte(tested_byte),
        .ccr(ccr), .irq_line_high(irq_line_high), .group(group), .mode(mode), .length(length),
        .unassigned(unassigned), .op_sel(op_sel), .bit_number(bit_number), .bit_sense(bit_sense),
        .effective_location(effective_location), .next_pc_out(next_pc_out), .branch_taken(branch_taken),
        .carry_from_bit(carry_from_bit), .dec_valid(dec_valid));

    // 20 MHz core clock
    initial begin
        forever #25 core_clk = ~core_clk;
    end

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One request at PCB, then the one-cycle answer is looked at while it stands
    task automatic issue(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2);
        @(posedge core_clk);
        u_fetch.put(PCB, op, b1, b2);
        pc <= PCB;
        fetch_valid <= 1'b1;
        @(posedge core_clk);
        fetch_valid <= 1'b0;
        @(negedge core_clk);
        chk("dec_valid", 16'h0001, {15'h0, dec_valid});
    endtask

    // Every opcode: group, mode, length, selector, hole flag; address unless implied or branch offset mode; counter advance unless branch, 8x/9x or jump
    task automatic test_sweep();
        logic [7:0] op;
        logic [3:0] h, l;
        logic un, jmp;
        logic [15:0] ea;
        @(posedge core_clk);
        index_reg <= 8'hf3;
        for (int i = 0; i < 256; i++) begin
            op = 8'(i);
            h = op[7:4];
            l = op[3:0];
            un = (h inside {[4'h3:4'h7]} && (l inside {4'h1, 4'h5, 4'hb, 4'he} || (l == 4'h2 && op != CAD_MUL_OPCODE)))
                || (h == 4'h8 && !(l inside {4'h0, 4'h1, 4'h3, 4'he, 4'hf}))
                || (h == 4'h9 && !(l inside {4'h7, [4'h8:4'hd], 4'hf})) || (op inside {8'ha7, 8'hac, 8'haf});
            jmp = h >= 4'ha && (l == 4'hc || l == 4'hd);
            case (mode_tab[h])
                operand_in_instruction_mode: ea = PCB + 16'h0001;
                long_absolute_mode: ea = 16'h2cd9;
                indexed_no_offset_mode: ea = 16'h00f3;
                indexed_byte_offset_mode: ea = 16'h00f3 + 16'h002c;
                indexed_word_offset_mode: ea = 16'h2cd9 + 16'h00f3;
                default: ea = 16'h002c;
            endcase
            issue(op, 8'h2c, 8'hd9);
            chk("group", {13'h0, (op == CAD_MUL_OPCODE) ? grp_control : grp_tab[h]}, {13'h0, group});
            chk("mode", {12'h0, (op == CAD_BSR_OPCODE) ? branch_offset_mode : mode_tab[h]}, {12'h0, mode});
            chk("length", {13'h0, len_tab[h]}, {13'h0, length});
            chk("op_sel", {12'h0, l}, {12'h0, op_sel});
            chk("unassigned", {15'h0, un}, {15'h0, unassigned});
            if (!jmp && (h == 4'h1 || (h > 4'h2 && h < 4'h8) || h > 4'h9)) begin
                chk("next_pc", PCB + 16'(len_tab[h]), next_pc_out);
            end
            if (mode_tab[h] != implied_mode && h != 4'h2 && op != CAD_BSR_OPCODE) begin
                chk("effective_location", ea, effective_location);
            end
            if (h < 4'h2) begin
                chk("bit_number", {13'h0, op[3:1]}, {13'h0, bit_number});
                chk("bit_sense", {15'h0, op[0]}, {15'h0, bit_sense});
            end
        end
        $display("test_sweep done");
    endtask

    // Sixteen branch conditions against four flag patterns, backward offset
    task automatic test_branch();
        logic [7:0] c;
        logic t;
        for (int i = 0; i < 64; i++) begin
            c = (i[5:4] == 2'h0) ? 8'h00 : (i[5:4] == 2'h1) ? 8'h1f : (i[5:4] == 2'h2) ? 8'h05 : 8'h1a;
            @(posedge core_clk);
            ccr <= c;
            irq_line_high <= i[4];
            case (i[3:1])
                3'h0: t = 1'b1;
                3'h1: t = !(c[0] | c[1]);
                3'h2: t = !c[0];
                3'h3: t = !c[1];
                3'h4: t = !c[4];
                3'h5: t = !c[2];
                3'h6: t = !c[3];
                default: t = !i[4];
            endcase
            t = t ^ i[0];
            issue({4'h2, 4'(i)}, 8'hf0, 8'h55);
            chk("branch_taken", {15'h0, t}, {15'h0, branch_taken});
            chk("next_pc", t ? PCB + 16'h0002 + 16'hfff0 : PCB + 16'h0002, next_pc_out);
        end
        issue(CAD_BSR_OPCODE, 8'h10, 8'h55);
        chk("next_pc", PCB + 16'h0012, next_pc_out);
        $display("test_branch done");
    endtask

    // Bit test-and-branch over all eight bits and both senses
    task automatic test_bit_branch();
        logic b, t;
        @(posedge core_clk);
        tested_byte <= 8'ha5;
        for (int i = 0; i < 16; i++) begin
            b = 1'(8'ha5 >> i[3:1]);
            t = b ^ i[0];
            issue(8'(i), 8'h40, 8'h7f);
            chk("carry_from_bit", {15'h0, b}, {15'h0, carry_from_bit});
            chk("branch_taken", {15'h0, t}, {15'h0, branch_taken});
            chk("next_pc", t ? PCB + 16'h0082 : PCB + 16'h0003, next_pc_out);
        end
        $display("test_bit_branch done");
    endtask

    // Effective address holds and dec_valid drops while no request is taken
    task automatic test_hold();
        issue(8'hc6, 8'h12, 8'h34);
        @(posedge core_clk);
        pc <= 16'h0100;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk("effective_location", 16'h1234, effective_location);
        chk("dec_valid", 16'h0000, {15'h0, dec_valid});
        $display("test_hold done");
    endtask

    task automatic conclude();
        $display("Counts: %0d checks, %0d mismatches", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog: the tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        err_total++;
        conclude();
    end

    // Reset, reset values, then the scenarios
    initial begin
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        @(negedge core_clk);
        chk("group", {13'h0, grp_control}, {13'h0, group});
        chk("length", 16'h0001, {13'h0, length});
        chk("mode", {12'h0, implied_mode}, {12'h0, mode});
        chk("dec_valid", 16'h0000, {15'h0, dec_valid});
        $display("test_reset done");
        test_sweep();
        test_branch();
        test_bit_branch();
        test_hold();
        conclude();
    end
endmodule // cad_opcode_decoder_tb_top
`default_nettype wire
